/* File: design/pfp_regs.vh */
`ifndef PFP_REGS_VH
`define PFP_REGS_VH

// register byte addresses
`define PFP_ADR_CTRL       8'h00
`define PFP_ADR_STAT       8'h04
`define PFP_ADR_IRQ_STAT   8'h08
`define PFP_ADR_IRQ_EN     8'h0c
`define PFP_ADR_IRQ_CLR    8'h10

// control fields and reset value
`define PFP_CTRL_ORDER_MAN 0
`define PFP_CTRL_TX_RUN    1
`define PFP_CTRL_RST       2'h2

// status fields
`define PFP_STAT_TX_EMPTY  0
`define PFP_STAT_TX_FULL   1
`define PFP_STAT_RX_EMPTY  2
`define PFP_STAT_RX_FULL   3
`define PFP_STAT_ORD_FLAG  4
`define PFP_STAT_ORD_CNT   8

// interrupt bits, same layout in status, enable and clear
`define PFP_IRQ_RX_DROP    0
`define PFP_IRQ_TX_DROP    1
`define PFP_IRQ_TX_UNDER   2
`define PFP_IRQ_ORDER      3
`define PFP_IRQ_W          4
`define PFP_IRQ_EN_RST     4'h0

// timing counts in clk_i cycles
`define PFP_TX_DIV         8'h04
`define PFP_RX_OVS         8'h08

`endif

/* File: design/pfp_fifo.v */
`timescale 1ns/10ps
module pfp_fifo #(
  parameter W  = 16,
  parameter AW = 3
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         wr_valid_i,
  output wire         wr_ready_o,
  input  wire [W-1:0] wr_data_i,
  output wire         rd_valid_o,
  input  wire         rd_ready_i,
  output wire [W-1:0] rd_data_o
);
  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  reg [W-1:0]  mem [0:(1<<AW)-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0]   count;
  wire         do_wr;
  wire         do_rd;

  assign wr_ready_o = (count != DEPTH);
  assign rd_valid_o = (count != {(AW+1){1'b0}});
  assign rd_data_o  = mem[rptr];
  assign do_wr      = wr_valid_i & wr_ready_o;
  assign do_rd      = rd_ready_i & rd_valid_o;

  always @(posedge clk_i) begin
    if (do_wr) begin
      mem[wptr] <= wr_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wptr <= wptr + 1'b1;
      end
      if (do_rd) begin
        rptr <= rptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // pfp_fifo

/* File: design/pfp_port.v */
// Summary of operation
// RL1: a transmit parallel clock output is provided for fabric timing.
// RL2: the receive parallel clock is recovered from incoming serial data transitions.
// RL3: fabric supplies a transmit core clock timing transmit FIFO writes.
// RL4: fabric supplies a receive core clock timing receive FIFO reads.
// RL5: receive FIFO full flag is driven, updated on receive core clock.
// RL6: receive FIFO empty flag is driven, updated on receive core clock.
// RL7: transmit FIFO full flag is driven, updated on transmit core clock.
// RL8: transmit FIFO empty flag is driven, updated on transmit core clock.
// RL9: in manual mode, asserting ordering enable starts one byte ordering operation.
// RL10: fabric must deassert then reassert ordering enable for another operation.
// RL11: fabric holds ordering enable at least one recovered clock period.
// RL12: ordering flag is high in the recovered cycle the operation happens.
// RL13: fabric synchronises the ordering flag before using it.
// RL14: byte reversal exists only for 16 or 20 bit width; reverses words.
// RL15: reversal swaps upper and lower halves, control bits included.
`timescale 1ns/10ps
`include "pfp_regs.vh"
module pfp_port #(
  parameter       PMA_W   = 16,
  parameter       FIFO_AW = 3,
  parameter [7:0] TX_DIV  = `PFP_TX_DIV,
  parameter [7:0] RX_OVS  = `PFP_RX_OVS
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [7:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  output reg              irq_o,
  input  wire             tx_core_clk_i,
  input  wire             tx_wr_en_i,
  input  wire [PMA_W-1:0] tx_data_i,
  output reg              tx_clk_o,
  output reg  [PMA_W-1:0] tx_pma_data_o,
  output reg              tx_pma_valid_o,
  output reg              tx_fifo_full_o,
  output reg              tx_fifo_empty_o,
  input  wire             rx_serial_i,
  input  wire             rx_core_clk_i,
  input  wire             rx_rd_en_i,
  output reg              rx_clk_o,
  output reg  [PMA_W-1:0] rx_data_o,
  output reg              rx_valid_o,
  output reg              rx_fifo_full_o,
  output reg              rx_fifo_empty_o,
  input  wire             order_ena_i,
  output reg              order_flag_o,
  input  wire             byte_rev_ena_i
);
  localparam       HALF   = PMA_W / 2;
  localparam       REV_OK = (PMA_W == 16) || (PMA_W == 20);
  localparam       SW     = 7 + PMA_W;
  localparam [7:0] BCNT_LAST = PMA_W[7:0] - 8'h01;
  localparam [7:0] BCNT_HALF = HALF[7:0];
  localparam [7:0] OVS_MID   = RX_OVS >> 1;

  // upper half goes low, lower half goes high, control bits travel with their byte
  function [PMA_W-1:0] swap_halves;
    input [PMA_W-1:0] w;
    begin
      swap_halves = {w[HALF-1:0], w[PMA_W-1:HALF]};
    end
  endfunction

  // a bit changes only once the second and third stage agree
  function [SW-1:0] settle;
    input [SW-1:0] s2;
    input [SW-1:0] s3;
    input [SW-1:0] old;
    begin
      settle = (s2 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
    end
  endfunction

  wire [SW-1:0] pins = {tx_data_i, byte_rev_ena_i, order_ena_i, rx_rd_en_i,
                        tx_wr_en_i, rx_serial_i, rx_core_clk_i, tx_core_clk_i};
  reg  [SW-1:0] sync1;
  reg  [SW-1:0] sync2;
  reg  [SW-1:0] sync3;
  reg  [SW-1:0] clean;
  reg  [SW-1:0] clean_d;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1   <= {SW{1'b0}};
      sync2   <= {SW{1'b0}};
      sync3   <= {SW{1'b0}};
      clean   <= {SW{1'b0}};
      clean_d <= {SW{1'b0}};
    end else begin
      sync1   <= pins;
      sync2   <= sync1;
      sync3   <= sync2;
      clean   <= settle(sync2, sync3, clean);
      clean_d <= clean;
    end
  end

  wire txck_rise  = clean[0] & ~clean_d[0];
  wire txck_fall  = ~clean[0] & clean_d[0];
  wire rxck_rise  = clean[1] & ~clean_d[1];
  wire rxck_fall  = ~clean[1] & clean_d[1];
  wire ser_edge   = clean[2] ^ clean_d[2];
  wire ord_rise   = clean[5] & ~clean_d[5];
  wire rev_on     = REV_OK && clean[6];

  // registers
  reg [1:0]           ctrl;
  reg [`PFP_IRQ_W-1:0] irq_stat;
  reg [`PFP_IRQ_W-1:0] irq_en;
  reg [7:0]           ord_cnt;
  wire                bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire                bus_wr  = bus_req & wb_we_i & wb_sel_i[0];

  // tx side: fabric data and write enable are taken mid-period, on the falling
  // core clock edge, because they change together with its rising edge
  reg [PMA_W-1:0] tx_hold;
  reg             tx_wr_hold;
  wire            txf_wready;
  wire            txf_rvalid;
  wire [PMA_W-1:0] txf_rdata;
  wire            tx_push = txck_rise & tx_wr_hold;
  reg  [7:0]      tx_div_cnt;
  wire            tx_div_end = (tx_div_cnt == TX_DIV - 8'h01);
  wire            tx_pop = tx_div_end & ~tx_clk_o & ctrl[`PFP_CTRL_TX_RUN];

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_hold    <= {PMA_W{1'b0}};
      tx_wr_hold <= 1'b0;
    end else if (txck_fall) begin
      tx_hold    <= clean[SW-1:7];
      tx_wr_hold <= clean[3];
    end
  end

  pfp_fifo #(
    .W  (PMA_W),
    .AW (FIFO_AW)
  ) u_tx_fifo (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_valid_i (tx_push),    // [RL3]
    .wr_ready_o (txf_wready),
    .wr_data_i  (tx_hold),
    .rd_valid_o (txf_rvalid),
    .rd_ready_i (tx_pop),
    .rd_data_o  (txf_rdata)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_fifo_full_o  <= 1'b0;
      tx_fifo_empty_o <= 1'b1;
    end else if (txck_rise) begin
      tx_fifo_full_o  <= ~txf_wready; // [RL7]
      tx_fifo_empty_o <= ~txf_rvalid; // [RL8]
    end
  end

  // tx parallel clock by divider; a word leaves on each rising half
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_div_cnt     <= 8'h00;
      tx_clk_o       <= 1'b0;
      tx_pma_data_o  <= {PMA_W{1'b0}};
      tx_pma_valid_o <= 1'b0;
    end else begin
      tx_div_cnt <= tx_div_end ? 8'h00 : tx_div_cnt + 8'h01;
      if (tx_div_end) begin
        tx_clk_o <= ~tx_clk_o; // [RL1]
      end
      if (tx_pop) begin
        tx_pma_data_o  <= txf_rdata;
        tx_pma_valid_o <= txf_rvalid;
      end
    end
  end

  // rx clock and data recovery: phase counter realigned on every data edge,
  // bit sampled mid-cell; long runs without edges drift with clk_i accuracy
  reg  [7:0]       ph;
  reg  [7:0]       bcnt;
  reg  [PMA_W-1:0] rx_sr;
  reg              ord_pend;
  wire             bit_tick  = (ph == OVS_MID);
  wire             word_tick = bit_tick & (bcnt == BCNT_LAST);
  wire             ord_do    = word_tick & ord_pend;
  wire [PMA_W-1:0] rx_word   = {clean[2], rx_sr[PMA_W-1:1]};
  wire             rxf_wready;
  wire             rxf_rvalid;
  wire [PMA_W-1:0] rxf_rdata;
  reg              rx_rd_hold;
  wire             rx_pop = rxck_rise & rx_rd_hold & rxf_rvalid;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ph           <= 8'h00;
      bcnt         <= 8'h00;
      rx_sr        <= {PMA_W{1'b0}};
      rx_clk_o     <= 1'b0;
      ord_pend     <= 1'b0;
      order_flag_o <= 1'b0;
      ord_cnt      <= 8'h00;
    end else begin
      if (ser_edge) begin
        ph <= 8'h00; // [RL2]
      end else if (ph == RX_OVS - 8'h01) begin
        ph <= 8'h00;
      end else begin
        ph <= ph + 8'h01;
      end
      if (ord_rise & ctrl[`PFP_CTRL_ORDER_MAN]) begin
        ord_pend <= 1'b1; // [RL9] [RL10]
      end else if (ord_do) begin
        ord_pend <= 1'b0;
      end
      if (bit_tick) begin
        rx_sr    <= rx_word;
        rx_clk_o <= (bcnt < BCNT_HALF); // [RL2]
        if (word_tick) begin
          // ordering slips the word boundary by one byte
          bcnt         <= ord_do ? BCNT_HALF : 8'h00; // [RL9]
          order_flag_o <= ord_do;                     // [RL12]
          if (ord_do) begin
            ord_cnt <= ord_cnt + 8'h01;
          end
        end else begin
          bcnt <= bcnt + 8'h01;
        end
      end
    end
  end

  pfp_fifo #(
    .W  (PMA_W),
    .AW (FIFO_AW)
  ) u_rx_fifo (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_valid_i (word_tick),
    .wr_ready_o (rxf_wready),
    .wr_data_i  (rev_on ? swap_halves(rx_word) : rx_word), // [RL14] [RL15]
    .rd_valid_o (rxf_rvalid),
    .rd_ready_i (rx_pop),                                   // [RL4]
    .rd_data_o  (rxf_rdata)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_rd_hold      <= 1'b0;
      rx_data_o       <= {PMA_W{1'b0}};
      rx_valid_o      <= 1'b0;
      rx_fifo_full_o  <= 1'b0;
      rx_fifo_empty_o <= 1'b1;
    end else begin
      if (rxck_fall) begin
        rx_rd_hold <= clean[4];
      end
      if (rxck_rise) begin
        rx_valid_o      <= rx_pop;
        rx_fifo_full_o  <= ~rxf_wready; // [RL5]
        rx_fifo_empty_o <= ~rxf_rvalid; // [RL6]
        if (rx_pop) begin
          rx_data_o <= rxf_rdata;
        end
      end
    end
  end

  // interrupt events; a new event wins over a clear in the same cycle
  wire [`PFP_IRQ_W-1:0] irq_ev;
  assign irq_ev[`PFP_IRQ_RX_DROP]  = word_tick & ~rxf_wready;
  assign irq_ev[`PFP_IRQ_TX_DROP]  = tx_push & ~txf_wready;
  assign irq_ev[`PFP_IRQ_TX_UNDER] = tx_pop & ~txf_rvalid;
  assign irq_ev[`PFP_IRQ_ORDER]    = ord_do;

  wire                  clr_hit = bus_wr & (wb_adr_i == `PFP_ADR_IRQ_CLR);
  wire [`PFP_IRQ_W-1:0] irq_clr = clr_hit ? wb_dat_i[`PFP_IRQ_W-1:0]
                                          : {`PFP_IRQ_W{1'b0}};
  wire [`PFP_IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      `PFP_ADR_CTRL: begin
        rd_mux[1:0] = ctrl;
      end
      `PFP_ADR_STAT: begin
        rd_mux[`PFP_STAT_TX_EMPTY] = tx_fifo_empty_o;
        rd_mux[`PFP_STAT_TX_FULL]  = tx_fifo_full_o;
        rd_mux[`PFP_STAT_RX_EMPTY] = rx_fifo_empty_o;
        rd_mux[`PFP_STAT_RX_FULL]  = rx_fifo_full_o;
        rd_mux[`PFP_STAT_ORD_FLAG] = order_flag_o;
        rd_mux[`PFP_STAT_ORD_CNT+:8] = ord_cnt;
      end
      `PFP_ADR_IRQ_STAT: begin
        rd_mux[`PFP_IRQ_W-1:0] = irq_stat;
      end
      `PFP_ADR_IRQ_EN: begin
        rd_mux[`PFP_IRQ_W-1:0] = irq_en;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= `PFP_CTRL_RST;
      irq_en   <= `PFP_IRQ_EN_RST;
      irq_stat <= {`PFP_IRQ_W{1'b0}};
      irq_o    <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
      irq_stat <= next_irq_stat;
      irq_o    <= |(next_irq_stat & irq_en);
      if (bus_wr & (wb_adr_i == `PFP_ADR_CTRL)) begin
        ctrl <= wb_dat_i[1:0];
      end
      if (bus_wr & (wb_adr_i == `PFP_ADR_IRQ_EN)) begin
        irq_en <= wb_dat_i[`PFP_IRQ_W-1:0];
      end
    end
  end
endmodule // pfp_port

/* File: dv/pfp_port_monitor.sv */
`timescale 1ns/10ps
module pfp_port_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        irq_o,
  input wire        tx_clk_o,
  input wire        tx_fifo_full_o,
  input wire        tx_fifo_empty_o,
  input wire        rx_clk_o,
  input wire        rx_fifo_full_o,
  input wire        rx_fifo_empty_o,
  input wire        order_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("data without ack");
  property p_rst;
    $fell(rst_i) |-> !wb_ack_o && !irq_o && !order_flag_o && tx_fifo_empty_o
      && rx_fifo_empty_o && !tx_fifo_full_o && !rx_fifo_full_o;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_txfl; !(tx_fifo_full_o && tx_fifo_empty_o); endproperty
  a_txfl: assert property (p_txfl) else $error("tx full and empty");
  property p_rxfl; !(rx_fifo_full_o && rx_fifo_empty_o); endproperty
  a_rxfl: assert property (p_rxfl) else $error("rx full and empty");
  // period of eight clk_i with the default divider
  property p_txclk; $rose(tx_clk_o) |=> (!$rose(tx_clk_o))[*7] ##1 $rose(tx_clk_o); endproperty
  a_txclk: assert property (p_txclk) else $error("tx clock period");
  property p_ord; $rose(order_flag_o) |=> order_flag_o[*8]; endproperty
  a_ord: assert property (p_ord) else $error("order flag short");
  property p_rxclk; $rose(rx_clk_o) |=> (!$rose(rx_clk_o))[*8]; endproperty
  a_rxclk: assert property (p_rxclk) else $error("rx clock too fast");
endmodule // pfp_port_monitor

bind pfp_port pfp_port_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o),
  .tx_clk_o(tx_clk_o), .tx_fifo_full_o(tx_fifo_full_o), .tx_fifo_empty_o(tx_fifo_empty_o),
  .rx_clk_o(rx_clk_o), .rx_fifo_full_o(rx_fifo_full_o), .rx_fifo_empty_o(rx_fifo_empty_o),
  .order_flag_o(order_flag_o));

/* File: dv/pfp_fabric.sv */
`timescale 1ns/10ps
module pfp_fabric #(parameter [15:0] WORD = 16'hc35a) (
  input  wire go_i,
  input  wire order_flag_i,
  output reg  tx_core_clk_o = 1'b0,
  output reg  rx_core_clk_o = 1'b0,
  output reg  rx_serial_o = 1'b0,
  output reg  order_seen_o = 1'b0
);
  reg     s1 = 1'b0;
  integer b;
  // slow core clocks; edges kept off clk_i edges so pin sampling has no race
  initial #5 forever #100 tx_core_clk_o = ~tx_core_clk_o;
  initial #3 forever #110 rx_core_clk_o = ~rx_core_clk_o;
  // endless stream, first bit sent is bit 0; bits change between clk_i edges
  initial begin
    wait (go_i);
    #7;
    forever for (b = 0; b < 16; b = b + 1) begin
      rx_serial_o = WORD[b];
      #160;
    end
  end
  // two stages: the flag comes from another clock
  always @(posedge rx_core_clk_o) {order_seen_o, s1} <= {s1, order_flag_i};
endmodule // pfp_fabric

/* File: dv/pfp_port_bench.sv */
`timescale 1ns/10ps
`include "pfp_regs.vh"
module pfp_port_bench;
  localparam [15:0] WORD = 16'hc35a;
  reg clk_i = 0, rst_i = 1, cyc = 0, we = 0, wr = 0, rd = 0, ord = 0, rev = 0, go = 0;
  reg rx_chk = 0, seen = 0, rv = 0, tp = 0;
  reg [7:0] adr = 0;
  reg [31:0] dat = 0, q;
  reg [15:0] txd = 0, txq[$];
  wire [31:0] wb_dat_o;
  wire [15:0] tx_pma_data_o, rx_data_o;
  wire ack, irq_o, tcc, rcc, ser, tx_clk_o, tx_pma_valid_o, tx_full, tx_empty;
  wire rx_clk_o, rx_valid_o, rx_full, rx_empty, order_flag_o, oseen;
  integer n_mismatch = 0, num_checks = 0, seed = 64417, i, k, ord_n = 0, pops = 0, rot = 16;
  always #10 clk_i = ~clk_i;
  pfp_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
    .irq_o(irq_o), .tx_core_clk_i(tcc), .tx_wr_en_i(wr), .tx_data_i(txd), .tx_clk_o(tx_clk_o),
    .tx_pma_data_o(tx_pma_data_o), .tx_pma_valid_o(tx_pma_valid_o), .tx_fifo_full_o(tx_full),
    .tx_fifo_empty_o(tx_empty), .rx_serial_i(ser), .rx_core_clk_i(rcc), .rx_rd_en_i(rd),
    .rx_clk_o(rx_clk_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_fifo_full_o(rx_full), .rx_fifo_empty_o(rx_empty), .order_ena_i(ord),
    .order_flag_o(order_flag_o), .byte_rev_ena_i(rev));
  pfp_fabric #(.WORD(WORD)) fab_u (.go_i(go), .order_flag_i(order_flag_o),
    .tx_core_clk_o(tcc), .rx_core_clk_o(rcc), .rx_serial_o(ser), .order_seen_o(oseen));
  task report_and_stop;
    begin
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task hang;
    begin
      chk("timeout", 0, 1);
      report_and_stop;
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // hold the request until ack is sampled, then a gap cycle
  task wb(input w, input [7:0] a, input [31:0] d);
    integer t;
    begin
      cyc <= 1; we <= w; adr <= a; dat <= d; t = 0;
      @(posedge clk_i);
      while (ack !== 1'b1) begin
        @(posedge clk_i);
        t = t + 1;
        if (t > 50) hang;
      end
      q = wb_dat_o; cyc <= 0; we <= 0;
      @(posedge clk_i);
    end
  endtask
  // the word boundary is free after lock: the first word fixes the bit slot,
  // then a one-byte slip or a reversal each move it by half a word
  function [15:0] rotl(input [15:0] w, input integer n);
    rotl = (w << (n % 16)) | (w >> ((16 - n % 16) % 16));
  endfunction
  function integer find_rot(input [15:0] w);
    integer j;
    begin
      find_rot = 16;
      for (j = 0; j < 16; j = j + 1) if (w === rotl(WORD, j)) find_rot = j;
    end
  endfunction
  always @(posedge clk_i) begin
    rv <= rx_valid_o;
    if (oseen === 1'b1) seen <= 1;
    if (rx_valid_o === 1'b1 && !rv) begin
      pops <= pops + 1;
      if (rx_chk && rot == 16) rot = find_rot(rx_data_o);
      if (rx_chk) chk("rxword", rotl(WORD, rot + 8 * (ord_n + rev)), rx_data_o);
    end
  end
  initial begin
    wait_n(12);
    rst_i <= 0; go <= 1; rd <= 1;
    @(posedge clk_i);
    wb(0, `PFP_ADR_CTRL, 0); chk("ctrl", 2, q);
    wb(0, `PFP_ADR_STAT, 0); chk("stat", 5, q);
    wb(0, `PFP_ADR_IRQ_EN, 0); chk("irqen", 0, q);
    wb(0, 8'h20, 0); chk("unmap", 0, q);
    wb(1, `PFP_ADR_CTRL, 0);
    for (i = 0; i < 9; i = i + 1) begin
      @(posedge tcc); @(posedge clk_i);
      k = $random(seed); wr <= 1; txd <= k[15:0];
      if (i < 8) txq.push_back(k[15:0]);
    end
    @(posedge tcc); @(posedge clk_i); wr <= 0; @(posedge tcc); wait_n(8);
    chk("txfull", 1, tx_full);
    wb(0, `PFP_ADR_IRQ_STAT, 0); chk("txdrop", 2, q & 2);
    wb(1, `PFP_ADR_IRQ_EN, 2); wait_n(2); chk("irq_on", 1, irq_o);
    wb(1, `PFP_ADR_IRQ_EN, 0); wait_n(2); chk("irq_off", 0, irq_o);
    wb(1, `PFP_ADR_IRQ_EN, 2); wb(1, `PFP_ADR_IRQ_CLR, 6); wait_n(2); chk("irq_clr", 0, irq_o);
    wb(1, `PFP_ADR_CTRL, 2); k = 0; i = 0;
    while (k < 8) begin
      @(posedge clk_i);
      if (tx_clk_o === 1'b1 && !tp) begin
        wait_n(2);
        if (tx_pma_valid_o === 1'b1) begin
          chk("txword", txq[k], tx_pma_data_o);
          k = k + 1;
        end
      end
      tp = tx_clk_o; i = i + 1;
      if (i > 400) hang;
    end
    wait_n(40); chk("txempty", 1, tx_empty);
    wb(0, `PFP_ADR_IRQ_STAT, 0); chk("underrun", 4, q & 4);
    rx_chk <= 1; wait_n(700);
    rd <= 0; wait_n(1400); chk("rxfull", 1, rx_full);
    wb(0, `PFP_ADR_IRQ_STAT, 0); chk("rxdrop", 1, q & 1);
    rd <= 1; i = 0;
    while (rx_empty !== 1'b1) begin
      wait_n(1); i = i + 1;
      if (i > 2000) hang;
    end
    chk("rxnfull", 0, rx_full);
    rx_chk <= 0; ord <= 1; wait_n(300); ord <= 0; wait_n(300);
    wb(0, `PFP_ADR_STAT, 0); chk("ordauto", 0, q[15:8]);
    wb(1, `PFP_ADR_CTRL, 3); ord <= 1; wait_n(300);
    ord <= 0; wait_n(300);
    wb(0, `PFP_ADR_STAT, 0); chk("ordcnt", 1, q[15:8]);
    wb(0, `PFP_ADR_IRQ_STAT, 0); chk("ordirq", 8, q & 8);
    chk("ordsync", 1, seen);
    ord_n = 1; wait_n(400); rx_chk <= 1; wait_n(700);
    rev <= 1; rx_chk <= 0; wait_n(400); rx_chk <= 1; wait_n(700);
    chk("pops", 1, pops > 4);
    report_and_stop;
  end
endmodule // pfp_port_bench
